// ---- oltic_fifo.sv ----
// Synchronous FIFO of flip-flops between sample capture and line coder.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/10ps
module oltic_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             full;
   logic             empty;

   assign empty     = wr_q == rd_q;
   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   // Storage needs no reset; empty hides stale words
   always_ff @(posedge core_clk) begin
      if (in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule // oltic_fifo

// ---- oltic_framer_model.sv ----
// Framer model: per-channel transmit clocks and rail data for all eight channels.
// Assumes the bench calls park and frame; the clock stands still between frames.
`timescale 1ns/10ps
module oltic_framer_model #(
   parameter int HALF_NS = 24,
   parameter int GAP_NS  = 400
) (
   // Sampling edge chosen at the device
   input  wire logic  edge_rise,
   // Framer outputs
   output logic [7:0] chan_tx_clock,
   output logic [7:0] tx_pos_rail_in,
   output logic [7:0] tx_neg_rail_in
);
   initial begin
      chan_tx_clock = '0;
      tx_pos_rail_in = '0;
      tx_neg_rail_in = '0;
   end
   // Idle on the level before the sampling edge
   task automatic park();
      chan_tx_clock = {8{~edge_rise}};
   endtask
   // One bit per frame; the gap keeps the bit period above the pulse time
   task automatic frame(input logic [7:0] pos, input logic [7:0] neg);
      tx_pos_rail_in = pos;
      tx_neg_rail_in = neg;
      #HALF_NS chan_tx_clock = ~chan_tx_clock; // 48 ns frame clock
      #HALF_NS chan_tx_clock = ~chan_tx_clock;
      // Hold over: inverse shows on the data rail; neg kept as a level for coding select
      tx_pos_rail_in = ~pos;
      #GAP_NS;
   endtask
endmodule // oltic_framer_model

// ---- oltic_pkg.sv ----
// Package for the octal transmit input stage: register map, codes, carriers.
// Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register port.
package oltic_pkg;
   localparam int NCHAN      = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_NS     = 4;
   // Width of one line pulse, timed from the core clock
   localparam int PULSE_NS   = 200;
   localparam logic [5:0] PULSE_CYC = 6'((PULSE_NS + CLK_NS - 1) / CLK_NS);

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_CHAN_CTRL = 10'h000;
   localparam logic [9:0] IDX_GLOBAL    = 10'h082;
   localparam logic [9:0] IDX_STATUS    = 10'h083;
   localparam int GLB_HANDOVER_BIT = 7;
   localparam int GLB_E1_BIT       = 0;
   localparam int STS_ON_LSB       = 0;
   localparam int STS_OVR_LSB      = 8;
   localparam int STS_MODE_BIT     = 16;
   localparam logic [3:0] CTRL_RESET     = 4'h0;
   localparam logic       HANDOVER_RESET = 1'b0;
   localparam logic       E1_RESET       = 1'b0;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // Line symbol codes held in the coder delay line
   typedef enum logic [1:0] {
      CODE_ZERO  = 2'h0,
      CODE_MARK  = 2'h1,
      CODE_BIPOL = 2'h2,
      CODE_VIOL  = 2'h3
   } oltic_code_e;
   // Oldest to newest: 0 0 0 V B 0 V B
   localparam logic [15:0] B8ZS_PAT      = 16'h038E;
   // Newest four: B 0 0 V and 0 0 0 V
   localparam logic [7:0]  HDB3_EVEN_PAT = 8'h83;
   localparam logic [7:0]  HDB3_ODD_PAT  = 8'h03;

   typedef enum logic [1:0] {
      REG_NONE   = 2'h0,
      REG_CTRL   = 2'h1,
      REG_GLOBAL = 2'h3,
      REG_STATUS = 2'h2
   } oltic_reg_e;

   typedef struct packed {
      logic all_ones;
      logic ami;
      logic single_rail;
      logic turn_on;
   } oltic_ctrl_s;

   typedef struct packed {
      logic [2:0] chan;
      logic       pos;
      logic       neg;
   } oltic_word_s;

   localparam int WORD_W = $bits(oltic_word_s);
endpackage

// ---- oltic_tb.sv ----
// Testbench for the octal transmit input stage: registers, turn-on, rails, coding.
// Assumes the framer model drives the link pins, one bit per link frame.
`timescale 1ns/10ps
module testbench;
   logic        core_clk, reset;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, tx_edge_select, pin_or_register_mode;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]  chan_tx_clock, tx_pos_rail_in, tx_neg_rail_in, send_all_ones, chan_turn_on;
   logic [7:0]  line_out_plus, line_out_plus_oe_n, line_out_minus, line_out_minus_oe_n;
   logic [7:0]  seen_p, seen_m, wcnt, width;
   logic        clr_q = 1'b0;
   int          n_mismatch = 0;
   int          n_compared = 0;
   typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} oltic_row_s;
   localparam oltic_row_s ROWS [4] = '{
      '{12'h000, 32'h0000_000F, 32'h0000_000F, 2'h0},
      '{12'h01C, 32'hFFFF_FFF5, 32'h0000_0005, 2'h0},
      '{12'h208, 32'h0000_0081, 32'h0000_0081, 2'h0},
      '{12'h300, 32'h0000_0001, 32'h0000_0000, 2'h2}};

   oltic_top dut (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_edge_select, .pin_or_register_mode, .chan_tx_clock,
      .tx_pos_rail_in, .tx_neg_rail_in, .send_all_ones, .chan_turn_on, .line_out_plus,
      .line_out_plus_oe_n, .line_out_minus, .line_out_minus_oe_n);
   oltic_framer_model fr (.edge_rise(tx_edge_select), .chan_tx_clock, .tx_pos_rail_in,
      .tx_neg_rail_in);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Pulse bookkeeping; width is the last high run on channel 0 plus
   // Only this process writes the seen masks; clear asks through clr_q
   always @(posedge core_clk) begin
      seen_p <= clr_q ? line_out_plus : (seen_p | line_out_plus);
      seen_m <= clr_q ? line_out_minus : (seen_m | line_out_minus);
      wcnt <= line_out_plus[0] ? wcnt + 8'h01 : 8'h00;
      if (!line_out_plus[0] && wcnt != 8'h00) width <= wcnt;
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      chk_reg({24'h0, got}, {24'h0, exp});
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw = 1;
      bit w = 1;
      bit b = 1;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w || b) begin
         @(posedge core_clk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 0;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            b = 0;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar = 1;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (ar && s_axi_arready === 1'b1) begin
            ar = 0;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Pin effects land two edges after a change, enables one more
   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask
   task automatic clear();
      @(posedge core_clk);
      clr_q <= 1'b1;
      @(posedge core_clk);
      clr_q <= 1'b0;
   endtask
   task automatic frames(input int n, input logic [7:0] p, input logic [7:0] ng);
      repeat (n) fr.frame(p, ng);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200us;
      n_mismatch++;
      summarize();
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, send_all_ones, chan_turn_on} = '0;
      s_axi_wstrb = 4'hF;
      tx_edge_select = 1'b1;
      pin_or_register_mode = 1'b0; // Register control
      reset = 1'b1;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      chk_pin(line_out_plus_oe_n, 8'hFF);
      axi_rd(12'h000, rd, rs);
      chk_reg(rd, 32'h0000_0000);
      $display("test reset done");
      foreach (ROWS[i]) begin
         axi_wr(ROWS[i].a, ROWS[i].w, rs);
         chk_reg({30'h0, rs}, {30'h0, ROWS[i].e});
         axi_rd(ROWS[i].a, rd, rs);
         chk_reg(rd, ROWS[i].r);
         chk_reg({30'h0, rs}, {30'h0, ROWS[i].e});
      end
      axi_wr(12'h000, 32'h0000_0000, rs);
      axi_wr(12'h01C, 32'h0000_0000, rs);
      axi_wr(12'h208, 32'h0000_0000, rs);
      $display("test register table done");
      axi_wr(12'h008, 32'h0000_0001, rs);
      settle();
      chk_pin(line_out_minus_oe_n, 8'hFB);
      axi_rd(12'h20C, rd, rs);
      chk_reg(rd, 32'h0000_0004);
      axi_wr(12'h008, 32'h0000_0000, rs);
      chan_turn_on <= 8'h30;
      axi_wr(12'h208, 32'h0000_0080, rs);
      settle();
      chk_pin(line_out_plus_oe_n, 8'hCF);
      axi_wr(12'h208, 32'h0000_0000, rs);
      settle();
      chk_pin(line_out_plus_oe_n, 8'hFF);
      pin_or_register_mode <= 1'b1;
      chan_turn_on <= 8'h81;
      settle();
      chk_pin(line_out_minus_oe_n, 8'h7E);
      axi_rd(12'h20C, rd, rs);
      chk_reg(rd, 32'h0001_0081);
      $display("test turn-on done");
      chan_turn_on <= 8'hFF;
      for (int e = 1; e >= 0; e--) begin
         tx_edge_select <= e[0];
         settle();
         fr.park();
         settle();
         clear();
         fr.frame(8'hA5, 8'h5A);
         chk_pin(seen_p, 8'hA5);
         chk_pin(seen_m, 8'h5A);
      end
      chk_pin(width, 8'(oltic_pkg::PULSE_CYC));
      chan_turn_on <= 8'h0F;
      settle();
      clear();
      fr.frame(8'hFF, 8'h00);
      chk_pin(seen_p, 8'h0F);
      $display("test dual rail done");
      chan_turn_on <= 8'hFF;
      axi_wr(12'h000, 32'h0000_0002, rs);
      axi_wr(12'h004, 32'h0000_0002, rs);
      clear();
      frames(24, 8'h00, 8'h02);
      chk_pin(seen_p | seen_m, 8'h01);
      clear();
      frames(16, 8'hFF, 8'h02);
      chk_pin(seen_p, 8'hFF);
      chk_pin(seen_m, 8'h03);
      $display("test single rail done");
      axi_wr(12'h000, 32'h0000_0000, rs);
      axi_wr(12'h004, 32'h0000_0000, rs);
      send_all_ones <= 8'h10;
      settle();
      clear();
      frames(12, 8'h00, 8'h00);
      chk_pin(seen_p, 8'h10);
      chk_pin(seen_m, 8'h10);
      send_all_ones <= 8'h00;
      frames(10, 8'h00, 8'h00);
      clear();
      frames(4, 8'h00, 8'h00);
      chk_pin(seen_p | seen_m, 8'h00);
      $display("test all ones done");
      summarize();
   end
endmodule // testbench

// ---- oltic_top.sv ----
// Octal transmit input stage: pin sampling, line coding, driver enables.
// Assumes framer pins are asynchronous to core_clk; registers over AXI4-Lite.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - Data are sampled on rising transmit clock edges when edge select is high, else falling.
// - In dual-rail use the positive input drives positive pulses and the negative negative.
// - In single-rail use the positive input is NRZ data and the negative carries none.
// - A low coding select gives B8ZS (T1) or HDB3 (E1) coding, a high one plain AMI.
// - The transmit clock only samples data; pulse timing comes from the core clock.
// - A high all-ones input sends continuous ones, a low one ends them.
// - A high turn-on input enables a channel, a low one floats its line driver.
// - In register mode a per-channel control bit turns each channel on or off.
// - Bit 7 of the register at 0x82 hands turn-on control to the pins.
// - Mode pin high selects pin control, low selects register control.
module oltic_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Framer pins
   input  wire logic        tx_edge_select,
   input  wire logic        pin_or_register_mode,
   input  wire logic [7:0]  chan_tx_clock,
   input  wire logic [7:0]  tx_pos_rail_in,
   input  wire logic [7:0]  tx_neg_rail_in,
   input  wire logic [7:0]  send_all_ones,
   input  wire logic [7:0]  chan_turn_on,
   // Line driver
   output logic [7:0]       line_out_plus,
   output logic [7:0]       line_out_plus_oe_n,
   output logic [7:0]       line_out_minus,
   output logic [7:0]       line_out_minus_oe_n
);
   localparam int NC = oltic_pkg::NCHAN;
   localparam int SW = 5 * NC + 2;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   function automatic oltic_pkg::oltic_reg_e reg_kind(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      if (idx[9:3] == oltic_pkg::IDX_CHAN_CTRL[9:3]) begin
         reg_kind = oltic_pkg::REG_CTRL;
      end else if (idx == oltic_pkg::IDX_GLOBAL) begin
         reg_kind = oltic_pkg::REG_GLOBAL;
      end else if (idx == oltic_pkg::IDX_STATUS) begin
         reg_kind = oltic_pkg::REG_STATUS;
      end else begin
         reg_kind = oltic_pkg::REG_NONE;
      end
   endfunction

   function automatic logic [2:0] first_set(input logic [7:0] v);
      first_set = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 3'(i);
         end
      end
   endfunction

   // Pin synchronisers
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic          edge_sel_s;
   logic          pin_mode_s;
   logic [7:0]    tclk_s;
   logic [7:0]    pos_s;
   logic [7:0]    neg_s;
   logic [7:0]    ones_s;
   logic [7:0]    on_s;
   logic [7:0]    line_code_select;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {tx_edge_select, pin_or_register_mode, chan_tx_clock,
                     tx_pos_rail_in, tx_neg_rail_in, send_all_ones, chan_turn_on};
         sync2_q <= sync1_q;
      end
   end
   assign {edge_sel_s, pin_mode_s, tclk_s, pos_s, neg_s, ones_s, on_s} = sync2_q;
   // Negative rail pin doubles as coding select in single-rail use under pin control; register control uses the ami bit
   assign line_code_select = neg_s;

   // Registers
   oltic_pkg::oltic_ctrl_s ctrl_q [NC];
   logic                   hand_q;
   logic                   e1_q;
   logic [7:0]             ovr_q;
   logic [7:0]             ones_eff;
   logic [7:0]             on_eff;
   logic [7:0]             ami_eff;

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         ones_eff[c] = pin_mode_s ? ones_s[c] : ctrl_q[c].all_ones;
         on_eff[c]   = (pin_mode_s || hand_q) ? on_s[c] : ctrl_q[c].turn_on;
         ami_eff[c]  = pin_mode_s ? line_code_select[c] : ctrl_q[c].ami;
      end
   end

   // Edge capture, one sample held per channel until queued
   logic [7:0] tclk_p_q;
   logic [7:0] cap;
   logic [7:0] pend_q;
   logic [7:0] hpos_q;
   logic [7:0] hneg_q;
   logic [2:0] g;
   logic       fifo_in_ready;
   logic       grant;

   // One select for every channel
   assign cap   = edge_sel_s ? (tclk_s & ~tclk_p_q) : (~tclk_s & tclk_p_q);
   assign g     = first_set(pend_q);
   assign grant = (|pend_q) && fifo_in_ready;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         tclk_p_q <= '0;
         pend_q   <= '0;
         hpos_q   <= '0;
         hneg_q   <= '0;
      end else begin
         tclk_p_q <= tclk_s;
         for (int c = 0; c < NC; c++) begin
            if (cap[c]) begin
               pend_q[c] <= 1'b1;
               hpos_q[c] <= pos_s[c];
               hneg_q[c] <= neg_s[c];
            end else if (grant && g == 3'(c)) begin
               pend_q[c] <= 1'b0;
            end
         end
      end
   end

   // Data FIFO; drain stalls while the channel's pulse is on the line
   oltic_pkg::oltic_word_s           in_word;
   oltic_pkg::oltic_word_s           head;
   logic [oltic_pkg::WORD_W-1:0]     fifo_out;
   logic                             fifo_out_valid;
   logic                             pop_ok;
   logic                             pop;
   logic [2:0]                       h;
   logic [5:0]                       timer_q [NC];

   assign in_word = '{chan: g, pos: hpos_q[g], neg: hneg_q[g]};
   assign head    = oltic_pkg::oltic_word_s'(fifo_out);
   assign h       = head.chan;
   assign pop_ok  = timer_q[h] == 6'h00;
   assign pop     = fifo_out_valid && pop_ok;

   oltic_fifo #(
      .WIDTH (oltic_pkg::WORD_W),
      .DEPTH (oltic_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_data   (in_word),
      .in_valid  (|pend_q),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (pop_ok)
   );

   // Line coder, eight-symbol delay line per channel for substitutions
   logic [15:0] sh_q [NC];
   logic [7:0]  par_q;
   logic [7:0]  pol_q;
   logic        coded;
   logic        mark;
   logic        par_d;
   logic        pol_d;
   logic        em_pos;
   logic        em_neg;
   logic [15:0] sh_d;
   logic [1:0]  ex;

   always_comb begin
      coded = ctrl_q[h].single_rail || ones_eff[h];
      mark  = head.pos || ones_eff[h];
      sh_d  = {sh_q[h][13:0], mark ? oltic_pkg::CODE_MARK : oltic_pkg::CODE_ZERO};
      par_d = par_q[h] ^ mark;
      if (ctrl_q[h].single_rail && !ami_eff[h]) begin
         if (!e1_q && sh_d == 16'h0000) begin
            sh_d = oltic_pkg::B8ZS_PAT;
         end else if (e1_q && sh_d[7:0] == 8'h00) begin
            sh_d[7:0] = par_q[h] ? oltic_pkg::HDB3_ODD_PAT : oltic_pkg::HDB3_EVEN_PAT;
            par_d     = 1'b0;
         end
      end
      ex     = sh_q[h][15:14];
      pol_d  = (ex == oltic_pkg::CODE_VIOL || ex == oltic_pkg::CODE_ZERO) ? pol_q[h] : ~pol_q[h];
      em_pos = coded ? (ex != oltic_pkg::CODE_ZERO && pol_d) : head.pos;
      em_neg = coded ? (ex != oltic_pkg::CODE_ZERO && !pol_d) : head.neg;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         par_q <= '0;
         pol_q <= '0;
         for (int c = 0; c < NC; c++) begin
            sh_q[c] <= '0;
         end
      end else if (pop && coded) begin
         sh_q[h]  <= sh_d;
         par_q[h] <= par_d;
         pol_q[h] <= pol_d;
      end
   end

   // Pulse shaping timed by core clock only
   logic [7:0] oe_n_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         line_out_plus  <= '0;
         line_out_minus <= '0;
         oe_n_q         <= '1;
         for (int c = 0; c < NC; c++) begin
            timer_q[c] <= '0;
         end
      end else begin
         oe_n_q <= ~on_eff;
         for (int c = 0; c < NC; c++) begin
            if (!on_eff[c]) begin
               timer_q[c]        <= '0;
               line_out_plus[c]  <= 1'b0;
               line_out_minus[c] <= 1'b0;
            end else if (pop && h == 3'(c) && (em_pos || em_neg)) begin
               timer_q[c]        <= oltic_pkg::PULSE_CYC;
               line_out_plus[c]  <= em_pos;
               line_out_minus[c] <= em_neg;
            end else if (timer_q[c] != 6'h00) begin
               timer_q[c] <= timer_q[c] - 6'h01;
               if (timer_q[c] == 6'h01) begin
                  line_out_plus[c]  <= 1'b0;
                  line_out_minus[c] <= 1'b0;
               end
            end
         end
      end
   end
   assign line_out_plus_oe_n  = oe_n_q;
   assign line_out_minus_oe_n = oe_n_q;

   // AXI4-Lite slave
   logic                   aw_full_q;
   logic                   w_full_q;
   logic [11:0]            awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic                   do_write;
   oltic_pkg::oltic_reg_e  wkind;
   oltic_pkg::oltic_reg_e  rkind;
   logic [31:0]            rd_value;

   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready  = !w_full_q;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wkind         = reg_kind(awaddr_q);
   assign rkind         = reg_kind(s_axi_araddr);

   always_comb begin
      unique case (rkind)
         oltic_pkg::REG_CTRL:   rd_value = {28'h000_0000, ctrl_q[s_axi_araddr[4:2]]};
         oltic_pkg::REG_GLOBAL: rd_value = {24'h00_0000, hand_q, 6'h00, e1_q};
         oltic_pkg::REG_STATUS: rd_value = {15'h0000, pin_mode_s, ovr_q, on_eff};
         oltic_pkg::REG_NONE:   rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_full_q    <= 1'b0;
         w_full_q     <= 1'b0;
         awaddr_q     <= '0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= oltic_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= oltic_pkg::RESP_OKAY;
         s_axi_rdata  <= '0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_q <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wkind == oltic_pkg::REG_NONE) ? oltic_pkg::RESP_SLVERR
                                                           : oltic_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= (rkind == oltic_pkg::REG_NONE) ? oltic_pkg::RESP_SLVERR
                                                           : oltic_pkg::RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         hand_q <= oltic_pkg::HANDOVER_RESET;
         e1_q   <= oltic_pkg::E1_RESET;
         for (int c = 0; c < NC; c++) begin
            ctrl_q[c] <= oltic_pkg::CTRL_RESET;
         end
      end else if (do_write && wstrb_q[0]) begin
         if (wkind == oltic_pkg::REG_CTRL) begin
            ctrl_q[awaddr_q[4:2]] <= wdata_q[3:0];
         end else if (wkind == oltic_pkg::REG_GLOBAL) begin
            hand_q <= wdata_q[oltic_pkg::GLB_HANDOVER_BIT];
            e1_q   <= wdata_q[oltic_pkg::GLB_E1_BIT];
         end
      end
   end

   // Overrun: new edge before the held sample was queued; set beats clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ovr_q <= '0;
      end else begin
         for (int c = 0; c < NC; c++) begin
            if (cap[c] && pend_q[c] && !(grant && g == 3'(c))) begin
               ovr_q[c] <= 1'b1;
            end else if (do_write && wkind == oltic_pkg::REG_STATUS && wstrb_q[1]
                         && wdata_q[oltic_pkg::STS_OVR_LSB + c]) begin
               ovr_q[c] <= 1'b0;
            end
         end
      end
   end

   for (genvar c = 0; c < NC; c++) begin : g_chk
      a_rise_capture: assert property (
         (edge_sel_s && tclk_s[c] && !tclk_p_q[c]) |=> pend_q[c] && hpos_q[c] == $past(pos_s[c]))
         else $error("rising edge sample missed");
      a_fall_capture: assert property (
         (!edge_sel_s && !tclk_s[c] && tclk_p_q[c]) |=> pend_q[c] && hneg_q[c] == $past(neg_s[c]))
         else $error("falling edge sample missed");
      a_off_hiz: assert property (
         !on_eff[c] |=> line_out_plus_oe_n[c] && !line_out_plus[c] && !line_out_minus[c])
         else $error("off channel still drives");
      a_reg_turn_on: assert property (
         (!pin_mode_s && !hand_q && ctrl_q[c].turn_on) |=> !line_out_minus_oe_n[c])
         else $error("register turn-on ignored");
      a_pin_handover: assert property (
         (!pin_mode_s && hand_q) |=> line_out_plus_oe_n[c] == !$past(on_s[c]))
         else $error("handover to pins failed");
      a_dual_pass: assert property (
         (pop && h == 3'(c) && !coded && on_eff[c] && head.pos)
         |=> line_out_plus[c] && line_out_minus[c] == $past(head.neg))
         else $error("dual rail data not passed");
      a_nrz_mark: assert property (
         (pop && h == 3'(c) && ctrl_q[c].single_rail && mark) |=> sh_q[c][1:0] != 2'h0)
         else $error("mark or all-ones lost");
      a_b8zs_sub: assert property (
         (pop && h == 3'(c) && ctrl_q[c].single_rail && !ami_eff[c] && !e1_q && !mark
          && sh_q[c][13:0] == 14'h0000) |=> sh_q[c] == oltic_pkg::B8ZS_PAT)
         else $error("zero substitution missing");
      a_ami_plain: assert property (
         (pop && h == 3'(c) && ctrl_q[c].single_rail && ami_eff[c] && !mark)
         |=> sh_q[c][1:0] == 2'h0)
         else $error("AMI zero altered");
      a_pulse_width: assert property (
         $rose(line_out_plus[c]) |-> ##49 (line_out_plus[c] || line_out_plus_oe_n[c])
         ##1 !line_out_plus[c])
         else $error("pulse width wrong");
   end
endmodule // oltic_top
